//--- hw/pts_pkg.sv
package pts_pkg;
	// Comparator modes
	localparam logic [2:0] PTS_MODE_OVER = 3'h0;
	localparam logic [2:0] PTS_MODE_OVER_ABS = 3'h1;
	localparam logic [2:0] PTS_MODE_UNDER = 3'h2;
	localparam logic [2:0] PTS_MODE_UNDER_ABS = 3'h3;
	localparam logic [2:0] PTS_MODE_DREL = 3'h4;
	localparam logic [2:0] PTS_MODE_DREL_ABS = 3'h5;
	localparam logic [2:0] PTS_MODE_DVAL = 3'h6;
	localparam logic [2:0] PTS_MODE_DVAL_ABS = 3'h7;
	// Condition codes
	localparam logic [1:0] PTS_COND_NORMAL = 2'h0;
	localparam logic [1:0] PTS_COND_START = 2'h1;
	localparam logic [1:0] PTS_COND_TRIP = 2'h2;
	localparam logic [1:0] PTS_COND_BLOCKED = 2'h3;
	// Event identities
	localparam logic [2:0] PTS_EV_START_ON = 3'h0;
	localparam logic [2:0] PTS_EV_START_OFF = 3'h1;
	localparam logic [2:0] PTS_EV_TRIP_ON = 3'h2;
	localparam logic [2:0] PTS_EV_TRIP_OFF = 3'h3;
	localparam logic [2:0] PTS_EV_BLOCK_ON = 3'h4;
	localparam logic [2:0] PTS_EV_BLOCK_OFF = 3'h5;
	// Timing
	localparam int PTS_CLK_MHZ = 250;
	localparam int PTS_DELAY_STEP_US = 5000;
	localparam int PTS_DELTA_WIN_US = 20000;
	localparam int PTS_CYC_PER_STEP = PTS_DELAY_STEP_US * PTS_CLK_MHZ;
	localparam int PTS_DELTA_STEPS = PTS_DELTA_WIN_US / PTS_DELAY_STEP_US;
	localparam logic [18:0] PTS_OP_DELAY_RST = 19'h0_0008;
	localparam logic [18:0] PTS_REL_DELAY_RST = 19'h0_000C;
	// Hysteresis in hundredths of a percent
	localparam logic [12:0] PTS_HYST_RST = 13'h012C;
	localparam int PTS_HYST_DEN = 10000;
	localparam int PTS_LOG_DEPTH = 12;
	localparam logic [3:0] PTS_LOG_LAST = 4'hB;
endpackage

//--- hw/pts_stage.sv
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// R1 - Mode 0: fulfilled when signed value exceeds pick-up level.
// R2 - Mode 1: fulfilled when magnitude exceeds pick-up level.
// R3 - Mode 2: fulfilled when value below level; inactive under blocking limit.
// R4 - Mode 3: magnitude below level; inactive under blocking limit.
// R5 - Mode 4: signed relative change over 20 ms exceeds relative pick-up.
// R6 - Mode 5: relative change over 20 ms exceeds pick-up either way.
// R7 - Mode 6: signed change in units over 20 ms exceeds pick-up.
// R8 - Mode 7: change in units over 20 ms exceeds pick-up either way.
// R9 - Pick-up level is per comparison and signed.
// R10 - Each level has own hysteresis, default three percent.
// R11 - Operate and release delays settable per stage.
// R12 - Blocking input sampled once at start of each processing cycle.
// R13 - Pick-up while unblocked asserts start, then times toward trip.
// R14 - Pick-up while blocked asserts blocked, no timing.
// R15 - Blocking during start clears start and runs release handling. The code clears start at once and skips the release delay.
// R16 - Blocking raises notification and logs time-stamped event with values.
// R17 - Stage forcing lets a software switch drive blocking.
// R18 - External blocking must arrive 5 ms before operate delay ends.
// R19 - Separate maskable on and off events for start, trip, blocked.
// R20 - Events carry timestamp and process data snapshot.
// R21 - Circular log of twelve latest on events, oldest overwritten.
// R22 - Log entry: time, event, magnitude, ratio, remaining time, group.
// R23 - Hysteresis is a percentage of the pick-up level.
// R24 - Delays 0 to 1800 s in 5 ms steps, defaults 40 and 60 ms.
// R25 - Condition encoding: normal 0, start 1, trip 2, blocked 3.
// R26 - Trip after operate delay of start; start drops after release delay.
module pts_stage
	import pts_pkg::*;
#(
	parameter int CYC_PER_STEP = PTS_CYC_PER_STEP
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Measurement
	input wire logic signed [31:0] meas_value,
	input wire logic [63:0] timestamp,
	input wire logic [2:0] active_setting_group,
	// Settings
	input wire logic [2:0] cmp_mode,
	input wire logic signed [31:0] pickup_level,
	input wire logic [12:0] hyst_setting,
	input wire logic hyst_load,
	input wire logic block_limit_en,
	input wire logic signed [31:0] block_limit,
	input wire logic [18:0] op_delay_steps,
	input wire logic [18:0] rel_delay_steps,
	input wire logic delay_load,
	input wire logic [5:0] event_mask,
	// Blocking
	input wire logic block_in,
	input wire logic force_enable,
	input wire logic force_block,
	// Status
	output logic start_out,
	output logic trip_out,
	output logic blocked_out,
	output logic [1:0] condition,
	output logic block_notify,
	output logic [18:0] time_remaining,
	// Event stream
	output logic event_valid,
	output logic [2:0] event_id,
	output logic [63:0] event_time,
	output logic signed [31:0] event_value,
	// Record log read port
	input wire logic [3:0] log_index,
	output logic [3:0] log_count,
	output logic [63:0] log_time,
	output logic [2:0] log_event,
	output logic signed [31:0] log_value,
	output logic signed [31:0] log_ratio,
	output logic [18:0] log_remaining,
	output logic [2:0] log_group
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_START = 3'b010,
		ST_TRIP = 3'b100
	} pts_st_t;

	typedef struct packed {
		logic [63:0] time_v;
		logic [2:0] ev;
		logic signed [31:0] value;
		logic signed [31:0] ratio;
		logic [18:0] rem;
		logic [2:0] grp;
	} pts_rec_t;

	typedef struct packed {
		logic [2:0] blk_sync;
		logic blk_filt;
		logic blk_q;
		logic start;
		logic [1:0] cond;
		logic [31:0] step_cnt;
		logic [18:0] timer;
		logic [18:0] rel_timer;
		pts_st_t st;
		logic blocked;
		logic picked;
		logic [12:0] hyst;
		logic [18:0] op_dly;
		logic [18:0] rel_dly;
		logic signed [31:0] hist0;
		logic signed [31:0] hist1;
		logic signed [31:0] hist2;
		logic signed [31:0] hist3;
		logic [5:0] ev_pend;
		logic ev_valid;
		logic [2:0] ev_id;
		logic [63:0] ev_time;
		logic signed [31:0] ev_val;
		logic notify;
		logic [3:0] wr_ptr;
		logic [3:0] count;
		pts_rec_t [PTS_LOG_DEPTH-1:0] log;
		pts_rec_t rd;
	} pts_state_t;

	pts_state_t s_q;
	pts_state_t s_d;

	logic signed [33:0] abs_v;
	logic signed [33:0] delta;
	logic signed [33:0] thr;
	logic signed [65:0] band;
	logic signed [33:0] hyst_amt;
	logic signed [65:0] rel_lhs;
	logic signed [65:0] rel_rhs;
	logic fulfilled;
	logic held;
	logic blk_now;
	logic cycle_tick;
	logic [5:0] changes;
	logic [2:0] pick_id;

	always_comb begin
		abs_v = (meas_value < 0) ? -34'(meas_value) : 34'(meas_value);
		delta = 34'(meas_value) - 34'(s_q.hist3);
		thr = 34'(pickup_level);
		band = 66'(thr) * 66'(s_q.hyst); // R23
		hyst_amt = 34'(band / 66'(PTS_HYST_DEN)); // R10
		if (hyst_amt < 0) begin
			hyst_amt = -hyst_amt;
		end
		rel_lhs = 66'(delta) * 66'(PTS_HYST_DEN);
		rel_rhs = 66'(thr) * 66'(s_q.hist3); // Relative pick-up taken in hundredths of percent
		fulfilled = 1'b0;
		held = 1'b0;
		case (cmp_mode)
			PTS_MODE_OVER: begin
				fulfilled = 34'(meas_value) > thr; // R1 R9
				held = 34'(meas_value) > thr - hyst_amt;
			end
			PTS_MODE_OVER_ABS: begin
				fulfilled = abs_v > thr; // R2
				held = abs_v > thr - hyst_amt;
			end
			PTS_MODE_UNDER: begin
				fulfilled = 34'(meas_value) < thr; // R3
				held = 34'(meas_value) < thr + hyst_amt;
			end
			PTS_MODE_UNDER_ABS: begin
				fulfilled = abs_v < thr; // R4
				held = abs_v < thr + hyst_amt;
			end
			PTS_MODE_DREL: begin
				fulfilled = rel_lhs > rel_rhs; // R5
				held = fulfilled;
			end
			PTS_MODE_DREL_ABS: begin
				fulfilled = (rel_lhs < 0 ? -rel_lhs : rel_lhs) > (rel_rhs < 0 ? -rel_rhs : rel_rhs); // R6
				held = fulfilled;
			end
			PTS_MODE_DVAL: begin
				fulfilled = delta > thr; // R7
				held = fulfilled;
			end
			default: begin
				fulfilled = (delta < 0 ? -delta : delta) > thr; // R8
				held = fulfilled;
			end
		endcase
		if ((cmp_mode == PTS_MODE_UNDER || cmp_mode == PTS_MODE_UNDER_ABS) && block_limit_en
			&& meas_value < block_limit) begin
			fulfilled = 1'b0; // R3 R4
			held = 1'b0;
		end
	end

	assign cycle_tick = (s_q.step_cnt == 32'(CYC_PER_STEP - 1));
	// A pin change counts only once the last two stages agree
	assign blk_now = force_enable ? force_block : s_q.blk_filt; // R17

	always_comb begin
		s_d = s_q;
		s_d.ev_valid = 1'b0;
		s_d.notify = 1'b0;
		s_d.blk_sync = {s_q.blk_sync[1:0], block_in};
		if (s_q.blk_sync[2] == s_q.blk_sync[1]) begin
			s_d.blk_filt = s_q.blk_sync[2];
		end
		if (hyst_load) begin
			s_d.hyst = hyst_setting; // R10
		end
		if (delay_load) begin
			s_d.op_dly = op_delay_steps; // R11 R24
			s_d.rel_dly = rel_delay_steps;
		end
		s_d.step_cnt = cycle_tick ? 32'h0000_0000 : s_q.step_cnt + 32'h0000_0001;
		if (cycle_tick) begin
			s_d.blk_q = blk_now; // R12
			s_d.hist3 = s_q.hist2;
			s_d.hist2 = s_q.hist1;
			s_d.hist1 = s_q.hist0;
			s_d.hist0 = meas_value;
			s_d.picked = s_q.picked ? held : fulfilled;
			case (s_q.st)
				ST_IDLE: begin
					if (s_d.picked && !s_d.blk_q) begin
						s_d.st = ST_START; // R13
						s_d.timer = s_q.op_dly;
					end
				end
				ST_START, ST_TRIP: begin
					if (s_d.blk_q || !s_d.picked) begin
						// Release timer runs for a drop-out; a block forces idle at once below
						if (s_q.rel_timer >= s_q.rel_dly) begin
							s_d.st = ST_IDLE; // R15 R26
							s_d.rel_timer = 19'h0_0000;
						end else begin
							s_d.rel_timer = s_q.rel_timer + 19'h0_0001;
						end
					end else begin
						s_d.rel_timer = 19'h0_0000;
						if (s_q.timer != 19'h0_0000) begin
							s_d.timer = s_q.timer - 19'h0_0001;
						end else begin
							s_d.st = ST_TRIP; // R26
						end
					end
					if (s_d.blk_q) begin
						s_d.st = ST_IDLE; // R15
						s_d.rel_timer = 19'h0_0000;
					end
				end
				default: s_d.st = ST_IDLE;
			endcase
			s_d.blocked = s_d.picked && s_d.blk_q; // R14
		end
		// Status kept in flops so the outputs carry no gates
		s_d.start = (s_d.st != ST_IDLE);
		s_d.cond = s_d.blocked ? PTS_COND_BLOCKED : (s_d.st == ST_TRIP) ? PTS_COND_TRIP :
			(s_d.st == ST_START) ? PTS_COND_START : PTS_COND_NORMAL; // R25
		changes = {
			~s_d.blocked & s_q.blocked, s_d.blocked & ~s_q.blocked,
			(s_q.st == ST_TRIP) & (s_d.st != ST_TRIP), (s_d.st == ST_TRIP) & (s_q.st != ST_TRIP),
			(s_q.st != ST_IDLE) & (s_d.st == ST_IDLE), (s_d.st != ST_IDLE) & (s_q.st == ST_IDLE)
		};
		if (changes[PTS_EV_BLOCK_ON]) begin
			s_d.notify = 1'b1; // R16
		end
		// Pending set wins over the clear below
		s_d.ev_pend = s_q.ev_pend | (changes & ~event_mask); // R19
		pick_id = PTS_EV_START_ON;
		for (int i = 5; i >= 0; i--) begin
			if (s_q.ev_pend[i]) begin
				pick_id = 3'(i);
			end
		end
		if (s_q.ev_pend != 6'h00) begin
			s_d.ev_valid = 1'b1;
			s_d.ev_id = pick_id;
			s_d.ev_time = timestamp; // R20
			s_d.ev_val = meas_value;
			s_d.ev_pend[pick_id] = changes[pick_id] & ~event_mask[pick_id];
		end
		if (changes[PTS_EV_START_ON] | changes[PTS_EV_TRIP_ON] | changes[PTS_EV_BLOCK_ON]) begin
			s_d.log[s_q.wr_ptr].time_v = timestamp; // R21 R22
			s_d.log[s_q.wr_ptr].ev = changes[PTS_EV_BLOCK_ON] ? PTS_EV_BLOCK_ON :
				changes[PTS_EV_TRIP_ON] ? PTS_EV_TRIP_ON : PTS_EV_START_ON;
			s_d.log[s_q.wr_ptr].value = meas_value;
			s_d.log[s_q.wr_ptr].ratio = (pickup_level == 0) ? 32'sh0000_0000 :
				32'(66'(meas_value) * 66'(PTS_HYST_DEN) / 66'(pickup_level));
			s_d.log[s_q.wr_ptr].rem = s_d.timer;
			s_d.log[s_q.wr_ptr].grp = active_setting_group;
			s_d.wr_ptr = (s_q.wr_ptr == PTS_LOG_LAST) ? 4'h0 : s_q.wr_ptr + 4'h1; // R21
			if (s_q.count != 4'(PTS_LOG_DEPTH)) begin
				s_d.count = s_q.count + 4'h1;
			end
		end
		s_d.rd = (log_index <= PTS_LOG_LAST) ? s_q.log[log_index] : '0;
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
			s_q.st <= ST_IDLE;
			s_q.hyst <= PTS_HYST_RST;
			s_q.op_dly <= PTS_OP_DELAY_RST;
			s_q.rel_dly <= PTS_REL_DELAY_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign start_out = s_q.start;
	assign trip_out = s_q.st[2];
	assign blocked_out = s_q.blocked;
	assign condition = s_q.cond; // R25
	assign block_notify = s_q.notify;
	assign time_remaining = s_q.timer;
	assign event_valid = s_q.ev_valid;
	assign event_id = s_q.ev_id;
	assign event_time = s_q.ev_time;
	assign event_value = s_q.ev_val;
	assign log_count = s_q.count;
	assign log_time = s_q.rd.time_v;
	assign log_event = s_q.rd.ev;
	assign log_value = s_q.rd.value;
	assign log_ratio = s_q.rd.ratio;
	assign log_remaining = s_q.rd.rem;
	assign log_group = s_q.rd.grp;

	AST_TRIP_NEEDS_START: assert property (@(posedge clk_sys) disable iff (!nrst) // R26
		$rose(trip_out) |-> $past(start_out)) else $error("Trip without prior start");
	AST_NO_START_BLOCKED: assert property (@(posedge clk_sys) disable iff (!nrst) // R14
		blocked_out |-> !start_out) else $error("Start while blocked");
	AST_BLOCK_CLEARS: assert property (@(posedge clk_sys) disable iff (!nrst) // R15
		(cycle_tick && s_d.blk_q && start_out) |=> !start_out) else $error("Start held under block");
	AST_COND_CODE: assert property (@(posedge clk_sys) disable iff (!nrst) // R25
		trip_out && !blocked_out |-> condition == 2'h2) else $error("Bad condition code");
	AST_NOTIFY: assert property (@(posedge clk_sys) disable iff (!nrst) // R16
		$rose(blocked_out) |-> block_notify) else $error("Missing block notice");
	AST_EVENT_TIME: assert property (@(posedge clk_sys) disable iff (!nrst) // R20
		event_valid |-> event_time == $past(timestamp)) else $error("Bad event time");
	AST_LOG_COUNT: assert property (@(posedge clk_sys) disable iff (!nrst) // R21
		log_count <= 4'hC) else $error("Log count overflow");
	AST_BLOCK_SAMPLE: assert property (@(posedge clk_sys) disable iff (!nrst) // R12
		!cycle_tick |=> $stable(s_q.blk_q)) else $error("Block sampled mid cycle");
	COV_TRIP: cover property (@(posedge clk_sys) disable iff (!nrst) $rose(trip_out));
	COV_BLOCK: cover property (@(posedge clk_sys) disable iff (!nrst) $rose(blocked_out));
	COV_EVENT: cover property (@(posedge clk_sys) disable iff (!nrst) event_valid);
endmodule
`default_nettype wire

//--- dv/pts_meas_src.sv
`timescale 1ns/10ps
`default_nettype none
module pts_meas_src (
	// Clock
	input wire logic clk_sys,
	// Bench requests
	input wire logic signed [31:0] value_req,
	input wire logic block_req,
	// Toward the stage
	output logic signed [31:0] meas_value,
	output logic block_in
);
	initial begin
		meas_value = '0;
		block_in = 1'b0;
	end
	// Moved off the sampling edge so the stage never samples mid-change
	always @(negedge clk_sys) begin
		meas_value <= value_req;
		block_in <= block_req;
	end
endmodule
`default_nettype wire

//--- dv/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
	import pts_pkg::*;
	localparam int CPS = 10;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic signed [31:0] meas_req = '0;
	logic signed [31:0] pickup_level = 32'sd500;
	logic [63:0] timestamp = '0;
	logic [2:0] grp = 3'h0, cmp_mode = 3'h0;
	logic [18:0] op_delay_steps = 19'h0_0002, rel_delay_steps = 19'h0_0001;
	logic delay_load = 1'b0, block_req = 1'b0, force_enable = 1'b0, force_block = 1'b0;
	logic [5:0] event_mask = 6'h00;
	logic [3:0] log_index = 4'h0;
	logic signed [31:0] meas_value;
	logic block_in, start_out, trip_out, blocked_out, block_notify, event_valid;
	logic [1:0] condition;
	logic [2:0] event_id, log_event, log_group;
	logic [3:0] log_count;
	logic [18:0] time_remaining, log_remaining;
	logic signed [31:0] log_value, log_ratio;
	logic [31:0] lfsr = 32'hc9c3;
	int failures = 0, n_compared = 0, cyc = 0, nnotify = 0;
	logic [2:0] evq[$];

	always #2 clk_sys = ~clk_sys;
	always @(negedge clk_sys) timestamp <= timestamp + 64'h1;

	pts_meas_src src (.clk_sys(clk_sys), .value_req(meas_req), .block_req(block_req),
		.meas_value(meas_value), .block_in(block_in));

	pts_stage #(.CYC_PER_STEP(CPS)) dut (.clk_sys(clk_sys), .nrst(nrst),
		.meas_value(meas_value), .timestamp(timestamp), .active_setting_group(grp),
		.cmp_mode(cmp_mode), .pickup_level(pickup_level), .hyst_setting(13'h012C),
		.hyst_load(1'b0), .block_limit_en(1'b1), .block_limit(-32'sd500),
		.op_delay_steps(op_delay_steps), .rel_delay_steps(rel_delay_steps),
		.delay_load(delay_load), .event_mask(event_mask), .block_in(block_in),
		.force_enable(force_enable), .force_block(force_block), .start_out(start_out),
		.trip_out(trip_out), .blocked_out(blocked_out), .condition(condition),
		.block_notify(block_notify), .time_remaining(time_remaining), .event_valid(event_valid),
		.event_id(event_id), .event_time(), .event_value(), .log_index(log_index),
		.log_count(log_count), .log_time(), .log_event(log_event), .log_value(log_value),
		.log_ratio(log_ratio), .log_remaining(log_remaining), .log_group(log_group));

	// Event collector for the bench model
	always @(posedge clk_sys) begin
		cyc++;
		if (event_valid === 1'b1)
			evq.push_back(event_id);
		if (block_notify === 1'b1)
			nnotify++;
		if (cyc == 30000) begin
			failures++;
			end_of_test();
		end
	end

	task automatic end_of_test();
		if (failures == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask

	task automatic ticks(input int n);
		repeat (n * CPS) @(negedge clk_sys);
	endtask

	task automatic do_reset();
		nrst = 1'b0;
		repeat (3) @(negedge clk_sys);
		evq.delete();
		nnotify = 0;
		nrst = 1'b1;
	endtask

	function automatic int iabs(input int v);
		return (v < 0) ? -v : v;
	endfunction

	// Magnitude kept well clear of the 500 thresholds and the hysteresis band
	function automatic int smag();
		lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h0400_0007 : 32'h0000_0000);
		return (lfsr[1] ? -1 : 1) * ((lfsr[0] ? 600 : 100) + int'(lfsr[15:4] % 300));
	endfunction

	function automatic logic fulfil(input int m, input int a, input int b, input int pk);
		int d;
		d = b - a;
		case (m)
			0: return b > pk;
			1: return iabs(b) > pk;
			2: return b < pk && b >= -500;
			3: return iabs(b) < pk && b >= -500;
			4: return d * 10000 > pk * a;
			5: return iabs(d) * 10000 > pk * a;
			6: return d > pk;
			default: return iabs(d) > pk;
		endcase
	endfunction

	function automatic int n_ev(input logic [2:0] id);
		int n;
		n = 0;
		foreach (evq[i])
			if (evq[i] === id)
				n++;
		return n;
	endfunction

	initial begin
		int a, b;
		logic e;
		do_reset();
		chk(condition, PTS_COND_NORMAL);
		chk(log_count, 4'h0);
		for (int m = 0; m < 8; m++) begin
			for (int k = 0; k < 2; k++) begin
				cmp_mode = m[2:0];
				pickup_level = (m == 4 || m == 5) ? 1000 : (k == 1 ? -500 : 500);
				a = (m < 4) ? smag() : 5000;
				b = (m < 4) ? a : a + smag();
				meas_req = a;
				do_reset();
				ticks(25);
				e = fulfil(m, a, a, pickup_level);
				chk(start_out, e);
				chk(trip_out, e);
				chk(condition, e ? PTS_COND_TRIP : PTS_COND_NORMAL);
				meas_req = b;
				repeat (35) @(negedge clk_sys);
				chk(start_out, e | fulfil(m, a, b, pickup_level));
			end
		end
		cmp_mode = PTS_MODE_OVER;
		pickup_level = 1000;
		meas_req = 1100;
		do_reset();
		ticks(25);
		meas_req = 985;
		ticks(25);
		chk(start_out, 1'b1);
		meas_req = 950;
		ticks(25);
		chk({start_out, trip_out}, 2'b00);
		delay_load = 1'b1;
		@(negedge clk_sys);
		delay_load = 1'b0;
		meas_req = 1100;
		ticks(5);
		chk(trip_out, 1'b1);
		chk(time_remaining, 19'h0_0000);
		meas_req = 0;
		ticks(4);
		chk(start_out, 1'b0);
		pickup_level = 500;
		meas_req = 700;
		do_reset();
		ticks(3);
		chk(condition, PTS_COND_START);
		block_req = 1'b1;
		ticks(3);
		chk(start_out, 1'b0);
		ticks(10);
		chk(trip_out, 1'b0);
		chk(n_ev(PTS_EV_START_OFF), 1);
		chk(n_ev(PTS_EV_TRIP_ON), 0);
		grp = lfsr[2:0];
		event_mask = lfsr[9:4];
		meas_req = 0;
		do_reset();
		ticks(1);
		for (int i = 0; i < 14; i++) begin
			if (i == 7) begin
				force_enable = 1'b1;
				force_block = 1'b1;
				block_req = 1'b0;
			end
			meas_req = 700;
			ticks(3);
			chk({blocked_out, start_out, condition}, {2'b10, PTS_COND_BLOCKED});
			meas_req = 0;
			ticks(15);
		end
		chk(n_ev(PTS_EV_BLOCK_ON), event_mask[4] ? 0 : 14);
		chk(n_ev(PTS_EV_BLOCK_OFF), event_mask[5] ? 0 : 14);
		chk(nnotify, 14);
		chk(log_count, 4'hC);
		for (int i = 0; i < PTS_LOG_DEPTH; i++) begin
			log_index = i[3:0];
			repeat (2) @(negedge clk_sys);
			chk({log_event, log_group}, {PTS_EV_BLOCK_ON, grp});
			chk({log_value, log_ratio}, {32'sd700, 32'sd14000});
			chk(log_remaining, 19'h0_0000);
		end
		end_of_test();
	end
endmodule
`default_nettype wire
